// [bank_param_defines.svh]
/*
  Offsets, field positions, reset values and timing constants of the
  bank 0 parameter register bank.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef BANK_PARAM_DEFINES_SVH
`define BANK_PARAM_DEFINES_SVH

`define OFF_VALID          8'h6c
`define OFF_MISC           8'h70
`define OFF_LAT_M1         8'h74
`define OFF_LAT_M2         8'h78
`define OFF_ROW_TIMING     8'h7c
`define REG_RESET          32'h0000_0000
`define VALID_RESET        1'b0

`define VALID_BIT          0
`define MISC_MASK          32'h00ff_ffff
`define LAT_M1_MASK        32'hff00_0000
`define LAT_M2_MASK        32'hff00_ff00
`define ROW_MASK           32'h00ff_ff00
`define VALID_MASK         32'h0000_0001

`define CAS_FIELD          23:16
`define LBANK_FIELD        15:8
`define BURST_FIELD        7:0
`define LAT_M1_FIELD       31:24
`define PRECHARGE_FIELD    31:24
`define LAT_M2_FIELD       15:8
`define ACTIVE_FIELD       23:16
`define RCD_FIELD          15:8
`define NIB_WHOLE          7:4
`define NIB_TENTH          3:0

`define PS_PER_NS          16'h03e8
`define PS_PER_TENTH       16'h0064
`define PS_PER_QUARTER     16'h00fa
`define CLK_PERIOD_PS      32'h0000_2710
`define CLK_PERIOD_NS      32'h0000_000a

`endif

// [bank_param_pkg.sv]
/*
  Types shared by the bank 0 parameter register bank.
  Assumes bank_param_defines.svh is included first by users needing offsets.
*/
package bank_param_pkg;

  typedef struct packed {
    logic [7:0] supported_cas_latency_mask;
    logic [7:0] logical_bank_count;
    logic [7:0] burst_length_mask;
    logic [7:0] cycle_time_latency_minus1;
    logic [7:0] cycle_time_latency_minus2;
    logic [7:0] row_precharge_min;
    logic [7:0] row_active_min;
    logic [7:0] row_to_column_delay;
  } bank_params_t;

  typedef struct packed {
    logic [7:0] row_precharge_cycles;
    logic [7:0] row_active_cycles;
    logic [7:0] row_to_column_cycles;
    logic [15:0] cycle_latency_minus1_ps;
    logic [15:0] cycle_latency_minus2_ps;
  } bank_timing_t;

  typedef enum logic [1:0] {
    ROW_IDLE,
    ROW_OPEN,
    ROW_PRECHARGE
  } row_state_t;

endpackage

// [bank_param_regs.sv]
/*
  Bank 0 memory parameter registers on APB, with row timing enforcement
  and compatibility check derived from the stored fields.
  Assumes an APB master on pclk; the controller drives activate,
  column and precharge requests synchronous to pclk.
  Read data is captured in the setup phase, so there are no wait states.
*/
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "bank_param_defines.svh"

module bank_param_regs
  import bank_param_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Controller requests
  input  wire logic              activate_req,
  input  wire logic              column_req,
  input  wire logic              precharge_req,
  input  wire logic [7:0]        want_burst_mask,
  input  wire logic [7:0]        want_cas_mask,
  // Controller grants and status
  output logic                   activate_ok,
  output logic                   column_ok,
  output logic                   precharge_ok,
  output logic                   bank0_compatible,
  output logic                   bank0_active,
  output logic [7:0]             bank0_logical_banks,
  output var bank_timing_t       bank0_timing
);

  logic [31:0]  misc_q;
  logic [31:0]  lat_m1_q;
  logic [31:0]  lat_m2_q;
  logic [31:0]  row_q;
  logic         bank0_config_valid_q;
  logic [31:0]  rdata_d;
  logic         hit_d;
  logic         wr_en;
  logic         rd_en;
  bank_params_t params;
  bank_timing_t timing_d;
  row_state_t   row_state_q;
  logic [7:0]   active_cnt_q;
  logic [7:0]   rcd_cnt_q;
  logic [7:0]   rp_cnt_q;
  logic         compat_q;
  logic         col_gate;
  logic         pre_gate;
  logic         act_gate;

  // Zero-wait APB slave
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && !penable && !pwrite;

  // Address match against one register offset
  function automatic logic reg_sel(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction

  // Any mapped offset
  function automatic logic decode_hit(input logic [ADDR_W-1:0] a);
    return reg_sel(a, `OFF_VALID) ||
           reg_sel(a, `OFF_MISC) ||
           reg_sel(a, `OFF_LAT_M1) ||
           reg_sel(a, `OFF_LAT_M2) ||
           reg_sel(a, `OFF_ROW_TIMING);
  endfunction

  assign hit_d = decode_hit(paddr);

  // Never an error: unmapped reads return zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Register writes; reserved bits masked off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      misc_q <= `REG_RESET;
    end else if (wr_en && reg_sel(paddr, `OFF_MISC)) begin
      misc_q <= pwdata & `MISC_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_m1_q <= `REG_RESET;
    end else if (wr_en && reg_sel(paddr, `OFF_LAT_M1)) begin
      lat_m1_q <= pwdata & `LAT_M1_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_m2_q <= `REG_RESET;
    end else if (wr_en && reg_sel(paddr, `OFF_LAT_M2)) begin
      lat_m2_q <= pwdata & `LAT_M2_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_q <= `REG_RESET;
    end else if (wr_en && reg_sel(paddr, `OFF_ROW_TIMING)) begin
      row_q <= pwdata & `ROW_MASK;
    end
  end

  // Valid bit gates every field below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank0_config_valid_q <= `VALID_RESET;
    end else if (wr_en && reg_sel(paddr, `OFF_VALID)) begin
      bank0_config_valid_q <= pwdata[`VALID_BIT];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      ADDR_W'(`OFF_MISC):       rdata_d = misc_q;
      ADDR_W'(`OFF_LAT_M1):     rdata_d = lat_m1_q;
      ADDR_W'(`OFF_LAT_M2):     rdata_d = lat_m2_q;
      ADDR_W'(`OFF_ROW_TIMING): rdata_d = row_q;
      ADDR_W'(`OFF_VALID):      rdata_d = {31'h0, bank0_config_valid_q} & `VALID_MASK;
      default:                  rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data registered at the end of the setup phase, so it
  // stands from a flop through the whole access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `REG_RESET;
    end else if (rd_en && hit_d) begin
      prdata <= rdata_d;
    end else begin
      prdata <= `REG_RESET;
    end
  end

  // Field extraction, gated by the valid bit
  always_comb begin
    params = '0;
    if (bank0_config_valid_q) begin
      params.supported_cas_latency_mask = misc_q[`CAS_FIELD];
      params.logical_bank_count         = misc_q[`LBANK_FIELD];
      params.burst_length_mask          = misc_q[`BURST_FIELD];
      params.cycle_time_latency_minus1  = lat_m1_q[`LAT_M1_FIELD];
      params.row_precharge_min          = lat_m2_q[`PRECHARGE_FIELD];
      params.cycle_time_latency_minus2  = lat_m2_q[`LAT_M2_FIELD];
      params.row_active_min             = row_q[`ACTIVE_FIELD];
      params.row_to_column_delay        = row_q[`RCD_FIELD];
    end
  end

  // Field to timing conversion
  bank_timing_decode u_decode (
    .params (params),
    .timing (timing_d)
  );

  // Derived timing, cleared while bank 0 is not valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank0_timing <= '0;
    end else if (bank0_config_valid_q) begin
      bank0_timing <= timing_d;
    end else begin
      bank0_timing <= '0;
    end
  end

  // Logical bank count seen by the controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank0_logical_banks <= 8'h00;
    end else begin
      bank0_logical_banks <= params.logical_bank_count;
    end
  end

  // True when every wanted bit is also offered
  function automatic logic mask_covered(input logic [7:0] want, input logic [7:0] have);
    return (want & ~have) == 8'h00;
  endfunction

  // Every wanted burst length and latency must be supported
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compat_q <= 1'b0;
    end else begin
      compat_q <= bank0_config_valid_q &&
                  mask_covered(want_burst_mask, params.burst_length_mask) &&
                  mask_covered(want_cas_mask, params.supported_cas_latency_mask);
    end
  end
  assign bank0_compatible = compat_q;

  // Row timing guard; grants are combinational, so a request
  // is taken at the edge that ends its granted cycle
  assign act_gate = bank0_config_valid_q && (row_state_q == ROW_IDLE);
  assign col_gate = (row_state_q == ROW_OPEN) && (rcd_cnt_q == 8'h00);
  assign pre_gate = (row_state_q == ROW_OPEN) && (active_cnt_q == 8'h00);
  assign activate_ok  = act_gate;
  assign column_ok    = col_gate;
  assign precharge_ok = pre_gate;
  assign bank0_active = (row_state_q == ROW_OPEN);

  // Row state: idle, open, then precharge for the loaded count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_state_q <= ROW_IDLE;
    end else begin
      unique case (row_state_q)
        ROW_IDLE: begin
          if (activate_req && act_gate) begin
            row_state_q <= ROW_OPEN;
          end
        end
        ROW_OPEN: begin
          if (precharge_req && pre_gate) begin
            row_state_q <= ROW_PRECHARGE;
          end
        end
        ROW_PRECHARGE: begin
          // Stays for the full precharge count
          if (rp_cnt_q <= 8'h01) begin
            row_state_q <= ROW_IDLE;
          end
        end
        default: begin
          row_state_q <= ROW_IDLE;
        end
      endcase
    end
  end

  // Cycles left before precharge is allowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_cnt_q <= 8'h00;
    end else if (row_state_q == ROW_IDLE && activate_req && act_gate) begin
      active_cnt_q <= timing_d.row_active_cycles - 8'h01;
    end else if (active_cnt_q != 8'h00) begin
      active_cnt_q <= active_cnt_q - 8'h01;
    end
  end

  // Cycles left before a column access is allowed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcd_cnt_q <= 8'h00;
    end else if (row_state_q == ROW_IDLE && activate_req && act_gate) begin
      rcd_cnt_q <= timing_d.row_to_column_cycles - 8'h01;
    end else if (rcd_cnt_q != 8'h00) begin
      rcd_cnt_q <= rcd_cnt_q - 8'h01;
    end
  end

  // Precharge countdown, loaded in full when the row closes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_cnt_q <= 8'h00;
    end else if (row_state_q == ROW_OPEN && precharge_req && pre_gate) begin
      rp_cnt_q <= timing_d.row_precharge_cycles;
    end else if (rp_cnt_q != 8'h00) begin
      rp_cnt_q <= rp_cnt_q - 8'h01;
    end
  end

endmodule
`default_nettype wire

// [bank_param_regs_asserts.sv]
/* Port checker for bank_param_regs.
   Assumes binding to every bank_param_regs instance. */
`timescale 1ns/100ps
`default_nettype none
module bank_param_regs_asserts #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              activate_req,
  input wire logic              column_req,
  input wire logic              precharge_req,
  input wire logic              activate_ok,
  input wire logic              column_ok,
  input wire logic              precharge_ok,
  input wire logic              bank0_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY: assert property (pready)
    else $error("pready low");
  AST_NO_SLVERR: assert property (!pslverr)
    else $error("pslverr high");
  AST_LOW_ZERO: assert property (psel && penable && !pwrite && paddr < 'h6c |-> prdata == 0)
    else $error("unmapped read not zero");
  AST_COL_ROW: assert property (column_ok |-> bank0_active)
    else $error("column grant without open row");
  AST_PRE_ROW: assert property (precharge_ok |-> bank0_active)
    else $error("precharge grant without open row");
  AST_ACT_OPENS: assert property (activate_req && activate_ok |=> bank0_active && !activate_ok)
    else $error("activate not taken");
  AST_ROW_HELD: assert property (bank0_active && !(precharge_req && precharge_ok) |=> bank0_active)
    else $error("row closed early");
  AST_PRE_CLOSES: assert property (precharge_req && precharge_ok |=> !bank0_active && !activate_ok)
    else $error("precharge not honoured");
  cover property (activate_req && activate_ok);
  cover property (column_ok);
  cover property (column_req && column_ok);
  cover property (precharge_req && precharge_ok);
endmodule
bind bank_param_regs bank_param_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .activate_req(activate_req), .column_req(column_req), .precharge_req(precharge_req),
  .activate_ok(activate_ok), .column_ok(column_ok), .precharge_ok(precharge_ok),
  .bank0_active(bank0_active));
`default_nettype wire

// [bank_timing_decode.sv]
/*
  Converts bank 0 parameter fields into clock counts and picoseconds.
  Assumes fields are stable from registers on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bank_param_defines.svh"

module bank_timing_decode
  import bank_param_pkg::*;
(
  // Fields in
  input  wire bank_params_t params,
  // Derived values
  output var bank_timing_t timing
);

  // Whole ns to cycles, rounded up, at least one
  function automatic logic [7:0] ns_to_cycles(input logic [7:0] ns);
    logic [31:0] c;
    c = ({24'h0, ns} + `CLK_PERIOD_NS - 32'h0000_0001) / `CLK_PERIOD_NS;
    if (c == 32'h0000_0000) begin
      c = 32'h0000_0001;
    end
    return c[7:0];
  endfunction

  always_comb begin
    timing.row_precharge_cycles = ns_to_cycles(params.row_precharge_min);
    timing.row_active_cycles    = ns_to_cycles(params.row_active_min);
    timing.row_to_column_cycles = ns_to_cycles(params.row_to_column_delay);
    // Upper nibble whole ns, lower nibble tenths
    timing.cycle_latency_minus1_ps =
      16'(params.cycle_time_latency_minus1[`NIB_WHOLE] * `PS_PER_NS) +
      16'(params.cycle_time_latency_minus1[`NIB_TENTH] * `PS_PER_TENTH);
    // Quarter-ns units
    timing.cycle_latency_minus2_ps =
      16'({8'h0, params.cycle_time_latency_minus2} * `PS_PER_QUARTER);
  end

endmodule
`default_nettype wire

// [testbench.sv]
/* Self-checking bench for bank_param_regs.
   Assumes the design package, defines header and checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "bank_param_defines.svh"
module testbench import bank_param_pkg::*;;
  logic         pclk, presetn, psel, penable, pwrite;
  logic         activate_req, column_req, precharge_req;
  logic [7:0]   paddr, want_burst_mask, want_cas_mask, bank0_logical_banks;
  logic [31:0]  pwdata, prdata, rd;
  logic         pready, pslverr, activate_ok, column_ok, precharge_ok;
  logic         bank0_compatible, bank0_active;
  bank_timing_t bank0_timing;
  int           n_errors = 0, check_count = 0, cycles = 0;
  bank_param_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .activate_req(activate_req), .column_req(column_req),
    .precharge_req(precharge_req), .want_burst_mask(want_burst_mask),
    .want_cas_mask(want_cas_mask), .activate_ok(activate_ok), .column_ok(column_ok),
    .precharge_ok(precharge_ok), .bank0_compatible(bank0_compatible),
    .bank0_active(bank0_active), .bank0_logical_banks(bank0_logical_banks),
    .bank0_timing(bank0_timing));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize;
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Two-cycle APB transfer, waits on pready, then one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_regs;
    logic [7:0]  offs [5] = '{`OFF_VALID, `OFF_MISC, `OFF_LAT_M1, `OFF_LAT_M2, `OFF_ROW_TIMING};
    logic [31:0] msk [5] = '{32'h1, 32'h00ffffff, 32'hff000000, 32'hff00ff00, 32'h00ffff00};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, offs[i], 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, offs[i], 32'hffffffff);
      apb(1'b0, offs[i], 32'h0);
      chk(rd, msk[i]);
    end
    apb(1'b1, 8'h80, 32'hffffffff);
    apb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_fields;
    apb(1'b1, `OFF_VALID, 32'h0);
    apb(1'b1, `OFF_MISC, 32'h0006040e);
    apb(1'b1, `OFF_LAT_M1, 32'h75000000);
    apb(1'b1, `OFF_LAT_M2, 32'h14002800);
    apb(1'b1, `OFF_ROW_TIMING, 32'h002d0f00);
    want_burst_mask <= 8'h02;
    want_cas_mask <= 8'h04;
    @(posedge pclk);
    #1;
    chk({bank0_logical_banks, activate_ok, bank0_compatible}, 10'h0);
    chk(bank0_timing, 56'h0);
    @(posedge pclk);
    apb(1'b1, `OFF_VALID, 32'h1);
    @(posedge pclk);
    #1;
    chk(bank0_logical_banks, 8'h04);
    chk(bank0_timing, {8'h02, 8'h05, 8'h02, 16'h1d4c, 16'h2710});
    chk(bank0_compatible, 1'b1);
    @(posedge pclk);
    want_burst_mask <= 8'h01;
    repeat (2) @(posedge pclk);
    #1;
    chk(bank0_compatible, 1'b0);
    @(posedge pclk);
    want_burst_mask <= 8'h02;
    want_cas_mask <= 8'h01;
    repeat (2) @(posedge pclk);
    #1;
    chk(bank0_compatible, 1'b0);
  endtask
  task automatic t_row;
    int n, nc, np;
    @(posedge pclk);
    activate_req <= 1'b1;
    precharge_req <= 1'b1;
    column_req <= 1'b1;
    @(posedge pclk);
    activate_req <= 1'b0;
    nc = 0;
    np = 0;
    for (n = 1; n < 20 && np == 0; n++) begin
      #1;
      if (column_ok === 1'b1 && nc == 0) nc = n;
      if (precharge_ok === 1'b1) np = n;
      if (np == 0) @(posedge pclk);
    end
    chk(nc, 2);
    chk(np, 5);
    @(posedge pclk);
    precharge_req <= 1'b0;
    column_req <= 1'b0;
    #1;
    chk({bank0_active, activate_ok}, 2'b00);
    @(posedge pclk);
    #1;
    chk(activate_ok, 1'b0);
    @(posedge pclk);
    #1;
    chk(activate_ok, 1'b1);
  endtask
  initial begin
    {psel, penable, pwrite, activate_req, column_req, precharge_req} = '0;
    {paddr, want_burst_mask, want_cas_mask, pwdata} = '0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_fields();
    t_row();
    summarize();
  end
endmodule
`default_nettype wire
